// ---- rtl/ife_regs.svh ----
// Register map, field positions, reset values and codes for the
// interrupt flag and enable unit. Definitions only.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef IFE_REGS_SVH
`define IFE_REGS_SVH

// Byte offsets of the four registers.
`define IFE_OFS_EDGE       5'h00
`define IFE_OFS_PRIMARY    5'h04
`define IFE_OFS_SECONDARY  5'h08
`define IFE_OFS_TERTIARY   5'h0c

// Reset value shared by every register.
`define IFE_RST_BYTE       8'h00

// Writable bit masks; the other bits read as zero.
`define IFE_MASK_EDGE      8'h0f
`define IFE_MASK_PRIMARY   8'h7f
`define IFE_MASK_SECONDARY 8'hff
`define IFE_MASK_TERTIARY  8'h33

// Edge select field positions and codes.
`define IFE_EDGE_PIN0_LSB  0
`define IFE_EDGE_PIN1_LSB  2
`define IFE_EDGE_NONE      2'h0
`define IFE_EDGE_RISE      2'h1
`define IFE_EDGE_FALL      2'h2
`define IFE_EDGE_BOTH      2'h3

// Primary control register fields.
`define IFE_PRI_CONV_F     6
`define IFE_PRI_PIN1_F     5
`define IFE_PRI_PIN0_F     4
`define IFE_PRI_CONV_E     3
`define IFE_PRI_PIN1_E     2
`define IFE_PRI_PIN0_E     1
`define IFE_PRI_GIE        0

// Secondary control register fields.
`define IFE_SEC_TB0_F      7
`define IFE_SEC_LV_F       6
`define IFE_SEC_MA_F       5
`define IFE_SEC_MP_F       4
`define IFE_SEC_TB0_E      3
`define IFE_SEC_LV_E       2
`define IFE_SEC_MA_E       1
`define IFE_SEC_MP_E       0

// Tertiary control register fields.
`define IFE_TER_EE_F       5
`define IFE_TER_TB1_F      4
`define IFE_TER_EE_E       1
`define IFE_TER_TB1_E      0

// Source indices; a lower index has the higher priority.
`define IFE_NSRC           9
`define IFE_SRC_PIN0       0
`define IFE_SRC_PIN1       1
`define IFE_SRC_CONV       2
`define IFE_SRC_MP         3
`define IFE_SRC_MA         4
`define IFE_SRC_LV         5
`define IFE_SRC_TB0        6
`define IFE_SRC_TB1        7
`define IFE_SRC_EE         8

`endif

// ---- rtl/ife_pkg.sv ----
// Types shared by the interrupt flag and enable unit.
// Assumes ife_regs.svh is compiled alongside.
package ife_pkg;
  typedef logic [7:0] ife_byte_t;
  typedef logic [8:0] ife_src_vec_t;
  typedef logic [3:0] ife_idx_t;
  typedef logic [1:0] ife_edge_t;
endpackage

// ---- rtl/ife_arb_if.sv ----
// Carries pending requests to the arbiter and its choice back.
// Assumes one clock domain; the arbiter is purely combinational.
`timescale 1ns/10ps
interface ife_arb_if;
  import ife_pkg::*;
  ife_src_vec_t pend;
  logic         any;
  ife_idx_t     idx;
  modport arb (input pend, output any, output idx);
  modport top (output pend, input any, input idx);
endinterface

// ---- rtl/ife_edge_det.sv ----
// Synchroniser and programmable edge detector for one external pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/10ps
`include "ife_regs.svh"
module ife_edge_det
  import ife_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_sys,
  input  wire logic      rstn,
  // Pin and mode.
  input  wire logic      pin_async,
  input  wire ife_edge_t edge_sel,
  // One-cycle detection.
  output logic           hit
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic rise;
  logic fall;

  // Two flops before any logic; the third keeps the previous sample.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // Successive samples give exactly one detection per transition.
  assign rise = sync2_reg & ~last_reg;
  assign fall = ~sync2_reg & last_reg;

  // Code none blocks the pin entirely.
  always_comb begin
    case (edge_sel)
      `IFE_EDGE_RISE: hit = rise;
      `IFE_EDGE_FALL: hit = fall;
      `IFE_EDGE_BOTH: hit = rise | fall;
      default:        hit = 1'b0;
    endcase
  end
endmodule

// ---- rtl/ife_prio_arb.sv ----
// Fixed priority arbiter over the enabled pending sources.
// Assumes index 0 is the most urgent source.
`timescale 1ns/10ps
`include "ife_regs.svh"
module ife_prio_arb
  import ife_pkg::*;
(
  // Requests in, choice out.
  ife_arb_if.arb ab
);
  // Scan downward so the lowest set index is the last one kept.
  always_comb begin
    ab.idx = '0;
    for (int i = `IFE_NSRC - 1; i >= 0; i--) begin
      if (ab.pend[i]) begin
        ab.idx = ife_idx_t'(i);
      end
    end
    ab.any = |ab.pend;
  end
endmodule

// ---- rtl/ife_unit.sv ----
// Interrupt flag and enable unit: edge select, three control registers,
// flag latching, fixed priority selection and the request to the core.
// Assumes an Avalon-MM master on clk_sys and a core that pulses irq_ack
// for one cycle when it takes the vector shown on irq_vector.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`include "ife_regs.svh"
module ife_unit
  import ife_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // External pins, asynchronous.
  input  wire logic        ext_pin0,
  input  wire logic        ext_pin1,
  // Peripheral events, one-cycle pulses on clk_sys.
  input  wire logic        converter_ovf,
  input  wire logic        timer_match_p,
  input  wire logic        timer_match_a,
  input  wire logic        low_voltage_evt,
  input  wire logic        timebase0_ovf,
  input  wire logic        timebase1_ovf,
  input  wire logic        eeprom_done,
  // Core side.
  input  wire logic        stack_full,
  input  wire logic        irq_ack,
  output logic             irq_req,
  output ife_idx_t         irq_vector
);

  ife_byte_t    edge_reg;
  ife_src_vec_t flag_reg;
  ife_src_vec_t enable_reg;
  logic         gie_reg;
  logic         wait_reg;
  logic [31:0]  rdata_reg;
  logic         irq_req_reg;
  ife_idx_t     irq_vec_reg;

  ife_src_vec_t set_vec;
  ife_src_vec_t ack_clr;
  ife_src_vec_t sw_flag;
  ife_src_vec_t sw_en;
  logic         wr_pri;
  logic         wr_sec;
  logic         wr_ter;
  logic         wr_edge;
  logic         do_write;
  logic         pin0_hit;
  logic         pin1_hit;
  ife_byte_t    wbyte;
  ife_byte_t    rd_byte;
  ife_byte_t    pri_view;
  ife_byte_t    sec_view;
  ife_byte_t    ter_view;

  ife_arb_if arb_bus ();

  // Edge detectors, one per pin, each steered by its own field.
  ife_edge_det u_pin0 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_async (ext_pin0),
    .edge_sel  (edge_reg[`IFE_EDGE_PIN0_LSB +: 2]),
    .hit       (pin0_hit)
  );

  ife_edge_det u_pin1 (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_async (ext_pin1),
    .edge_sel  (edge_reg[`IFE_EDGE_PIN1_LSB +: 2]),
    .hit       (pin1_hit)
  );

  // Every event source lands on its own flag index.
  always_comb begin
    set_vec                = '0;
    set_vec[`IFE_SRC_PIN0] = pin0_hit;
    set_vec[`IFE_SRC_PIN1] = pin1_hit;
    set_vec[`IFE_SRC_CONV] = converter_ovf;
    set_vec[`IFE_SRC_MP]   = timer_match_p;
    set_vec[`IFE_SRC_MA]   = timer_match_a;
    set_vec[`IFE_SRC_LV]   = low_voltage_evt;
    set_vec[`IFE_SRC_TB0]  = timebase0_ovf;
    set_vec[`IFE_SRC_TB1]  = timebase1_ovf;
    set_vec[`IFE_SRC_EE]   = eeprom_done;
  end

  // Register views as software sees them.
  always_comb begin
    pri_view = `IFE_RST_BYTE;
    pri_view[`IFE_PRI_CONV_F] = flag_reg[`IFE_SRC_CONV];
    pri_view[`IFE_PRI_PIN1_F] = flag_reg[`IFE_SRC_PIN1];
    pri_view[`IFE_PRI_PIN0_F] = flag_reg[`IFE_SRC_PIN0];
    pri_view[`IFE_PRI_CONV_E] = enable_reg[`IFE_SRC_CONV];
    pri_view[`IFE_PRI_PIN1_E] = enable_reg[`IFE_SRC_PIN1];
    pri_view[`IFE_PRI_PIN0_E] = enable_reg[`IFE_SRC_PIN0];
    pri_view[`IFE_PRI_GIE]    = gie_reg;
    sec_view = `IFE_RST_BYTE;
    sec_view[`IFE_SEC_TB0_F]  = flag_reg[`IFE_SRC_TB0];
    sec_view[`IFE_SEC_LV_F]   = flag_reg[`IFE_SRC_LV];
    sec_view[`IFE_SEC_MA_F]   = flag_reg[`IFE_SRC_MA];
    sec_view[`IFE_SEC_MP_F]   = flag_reg[`IFE_SRC_MP];
    sec_view[`IFE_SEC_TB0_E]  = enable_reg[`IFE_SRC_TB0];
    sec_view[`IFE_SEC_LV_E]   = enable_reg[`IFE_SRC_LV];
    sec_view[`IFE_SEC_MA_E]   = enable_reg[`IFE_SRC_MA];
    sec_view[`IFE_SEC_MP_E]   = enable_reg[`IFE_SRC_MP];
    ter_view = `IFE_RST_BYTE;
    ter_view[`IFE_TER_EE_F]   = flag_reg[`IFE_SRC_EE];
    ter_view[`IFE_TER_TB1_F]  = flag_reg[`IFE_SRC_TB1];
    ter_view[`IFE_TER_EE_E]   = enable_reg[`IFE_SRC_EE];
    ter_view[`IFE_TER_TB1_E]  = enable_reg[`IFE_SRC_TB1];
  end

  // Address decode; unmapped addresses read zero and drop writes.
  always_comb begin
    if (avs_address == `IFE_OFS_EDGE) begin
      rd_byte = edge_reg & `IFE_MASK_EDGE;
    end else if (avs_address == `IFE_OFS_PRIMARY) begin
      rd_byte = pri_view;
    end else if (avs_address == `IFE_OFS_SECONDARY) begin
      rd_byte = sec_view;
    end else if (avs_address == `IFE_OFS_TERTIARY) begin
      rd_byte = ter_view;
    end else begin
      rd_byte = `IFE_RST_BYTE;
    end
  end

  // A write lands at the edge where waitrequest is seen low.
  assign do_write = avs_write & ~wait_reg & avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign wr_edge  = do_write & (avs_address == `IFE_OFS_EDGE);
  assign wr_pri   = do_write & (avs_address == `IFE_OFS_PRIMARY);
  assign wr_sec   = do_write & (avs_address == `IFE_OFS_SECONDARY);
  assign wr_ter   = do_write & (avs_address == `IFE_OFS_TERTIARY);

  // Map written bytes back onto flag and enable indices.
  always_comb begin
    sw_flag                = flag_reg;
    sw_en                  = enable_reg;
    if (wr_pri) begin
      sw_flag[`IFE_SRC_CONV] = wbyte[`IFE_PRI_CONV_F];
      sw_flag[`IFE_SRC_PIN1] = wbyte[`IFE_PRI_PIN1_F];
      sw_flag[`IFE_SRC_PIN0] = wbyte[`IFE_PRI_PIN0_F];
      sw_en[`IFE_SRC_CONV]   = wbyte[`IFE_PRI_CONV_E];
      sw_en[`IFE_SRC_PIN1]   = wbyte[`IFE_PRI_PIN1_E];
      sw_en[`IFE_SRC_PIN0]   = wbyte[`IFE_PRI_PIN0_E];
    end
    if (wr_sec) begin
      sw_flag[`IFE_SRC_TB0]  = wbyte[`IFE_SEC_TB0_F];
      sw_flag[`IFE_SRC_LV]   = wbyte[`IFE_SEC_LV_F];
      sw_flag[`IFE_SRC_MA]   = wbyte[`IFE_SEC_MA_F];
      sw_flag[`IFE_SRC_MP]   = wbyte[`IFE_SEC_MP_F];
      sw_en[`IFE_SRC_TB0]    = wbyte[`IFE_SEC_TB0_E];
      sw_en[`IFE_SRC_LV]     = wbyte[`IFE_SEC_LV_E];
      sw_en[`IFE_SRC_MA]     = wbyte[`IFE_SEC_MA_E];
      sw_en[`IFE_SRC_MP]     = wbyte[`IFE_SEC_MP_E];
    end
    if (wr_ter) begin
      sw_flag[`IFE_SRC_EE]   = wbyte[`IFE_TER_EE_F];
      sw_flag[`IFE_SRC_TB1]  = wbyte[`IFE_TER_TB1_F];
      sw_en[`IFE_SRC_EE]     = wbyte[`IFE_TER_EE_E];
      sw_en[`IFE_SRC_TB1]    = wbyte[`IFE_TER_TB1_E];
    end
  end

  // The serviced source is the one last shown to the core.
  always_comb begin
    ack_clr = '0;
    if (irq_ack) begin
      ack_clr[irq_vec_reg] = 1'b1;
    end
  end

  // Bus handshake: one wait cycle, then a single low cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 1'b1;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (avs_read | avs_write) begin
      wait_reg <= 1'b0;
    end
  end

  // Read data is captured one edge early and stands until the next read.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read & wait_reg) begin
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // Edge register keeps only its four implemented bits.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      edge_reg <= `IFE_RST_BYTE;
    end else if (wr_edge) begin
      edge_reg <= wbyte & `IFE_MASK_EDGE;
    end
  end

  // Flags latch whatever the enables say; an event beats any clear.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (sw_flag & ~ack_clr) | set_vec;
    end
  end

  // Per-source enables are plain software bits.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= sw_en;
    end
  end

  // Service wins over a simultaneous software write, so nesting never
  // restarts behind the core's back.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gie_reg <= 1'b0;
    end else if (irq_ack) begin
      gie_reg <= 1'b0;
    end else if (wr_pri) begin
      gie_reg <= wbyte[`IFE_PRI_GIE];
    end
  end

  // Only flags with their enable set compete.
  assign arb_bus.pend = flag_reg & enable_reg;

  ife_prio_arb u_arb (
    .ab (arb_bus.arb)
  );

  // Request is withheld while the stack is full or the global enable is
  // low; it also drops in the cycle after the ack so one service is not seen twice.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= arb_bus.any & gie_reg
                     & ~stack_full & ~irq_ack;
    end
  end

  // Vector follows the highest priority enabled source.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_vec_reg <= '0;
    end else begin
      irq_vec_reg <= arb_bus.idx;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq_req         = irq_req_reg;
  assign irq_vector      = irq_vec_reg;

endmodule

// ---- bench/ife_unit_assertions.sv ----
// Port-level checks for the interrupt flag and enable unit.
// Assumes it is bound to ife_unit and sees its ports unchanged.
`timescale 1ns/10ps
`include "ife_regs.svh"
module ife_unit_assertions
  import ife_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register bus.
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and events.
  input wire logic        ext_pin0,
  input wire logic        ext_pin1,
  input wire logic        converter_ovf,
  input wire logic        timer_match_p,
  input wire logic        timer_match_a,
  input wire logic        low_voltage_evt,
  input wire logic        timebase0_ovf,
  input wire logic        timebase1_ovf,
  input wire logic        eeprom_done,
  // Core side.
  input wire logic        stack_full,
  input wire logic        irq_ack,
  input wire logic        irq_req,
  input wire ife_idx_t    irq_vector
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // A request is taken only at an edge where waitrequest stands high.
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_read_at(logic [4:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence
  a_req_answered: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus request not answered one cycle later");
  a_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_upper: assert property (
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_edge_upper: assert property (
    s_read_at(`IFE_OFS_EDGE) |=> avs_readdata[7:4] == 4'h0)
    else $error("edge register upper nibble not zero");
  // Holes in the map answer with zero rather than stalling the bus.
  a_hole_zero: assert property (
    avs_read && avs_waitrequest
    && (avs_address[4] || avs_address[1:0] != 2'h0)
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_full_blocks: assert property (stack_full |=> !irq_req)
    else $error("request raised while stack full");
  a_rise_room: assert property (
    $rose(irq_req) |-> $past(!stack_full))
    else $error("request rose after a full stack");
  a_ack_drops: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request stands after service");
  a_vector_range: assert property (irq_req |-> irq_vector <= 4'h8)
    else $error("vector outside the source range");
endmodule

// ---- bench/ife_core_model.sv ----
// Behavioural core: takes the shown vector after a chosen delay.
// Assumes the bench drives stack_full to the unit and here alike.
`timescale 1ns/10ps
module ife_core_model
  import ife_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Bench controls.
  input  wire logic       ack_en,
  input  wire logic [3:0] delay,
  input  wire logic       stack_full,
  // Unit side.
  input  wire logic       irq_req,
  input  wire ife_idx_t   irq_vector,
  output logic            irq_ack,
  // Record of service.
  output ife_idx_t        taken_vec,
  output logic [7:0]      taken_cnt
);
  logic [3:0] wait_reg;
  // Ack only while a request stands, so a one-cycle pulse never lands
  // on a dropped request; a full stack holds off service entirely.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      taken_vec <= 4'h0;
      taken_cnt <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (irq_ack) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
      if (irq_req && ack_en && !stack_full && !irq_ack) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg >= delay) begin
          irq_ack  <= 1'b1;
          wait_reg <= 4'h0;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

// ---- bench/ife_unit_test.sv ----
// Self-checking bench for the interrupt flag and enable unit.
// Assumes the unit, its header and the core model are compiled first.
`timescale 1ns/10ps
`include "ife_regs.svh"
module ife_unit_test;
  import ife_pkg::*;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, stack_full;
  logic irq_ack, irq_req, ack_en;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, delay;
  logic [1:0] ext_pin;
  logic [6:0] evt;
  ife_idx_t irq_vector, taken_vec;
  logic [7:0] taken_cnt, t;
  ife_byte_t q;
  int fails, samples_checked;
  logic [4:0] ofs [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
  ife_byte_t msk [5] = '{8'h0f, 8'h7f, 8'hff, 8'h33, 8'h00};
  logic [4:0] sofs [7] = '{5'h04, 5'h08, 5'h08, 5'h08, 5'h08, 5'h0c, 5'h0c};
  int sbit [7] = '{6, 4, 5, 6, 7, 4, 5};

  ife_unit ife_unit_inst (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_pin0(ext_pin[0]), .ext_pin1(ext_pin[1]), .converter_ovf(evt[0]),
    .timer_match_p(evt[1]), .timer_match_a(evt[2]),
    .low_voltage_evt(evt[3]), .timebase0_ovf(evt[4]),
    .timebase1_ovf(evt[5]), .eeprom_done(evt[6]), .stack_full(stack_full),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));
  ife_core_model ife_core_model_inst (.clk_sys(clk_sys), .rstn(rstn),
    .ack_en(ack_en), .delay(delay), .stack_full(stack_full),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;

  task automatic check(input ife_byte_t seen, input ife_byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; the request is held until waitrequest is seen low,
  // then one idle edge keeps back-to-back calls from clashing.
  task automatic bus(input logic w, input logic [4:0] a, input ife_byte_t d,
                     output ife_byte_t r);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    // No cycle count is assumed; only the watchdog ends a stalled wait.
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input ife_byte_t d);
    ife_byte_t r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [4:0] a, input ife_byte_t e);
    ife_byte_t r;
    bus(1'b0, a, 8'h00, r);
    check(r, e);
  endtask

  // Waits for the core model to take one more vector; a hang is left
  // to the watchdog, which counts it as a mismatch.
  task automatic wait_taken();
    while (taken_cnt == t) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the several hundred cycles needed.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  initial begin
    clk_sys = 0; rstn = 0; avs_address = 0; avs_read = 0; avs_write = 0;
    avs_writedata = 0; avs_byteenable = 4'hf; ext_pin = 0; evt = 0;
    stack_full = 0; ack_en = 0; delay = 0; fails = 0; samples_checked = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    // Reset values, writable bits and a hole in the map.
    for (int i = 0; i < 5; i++) begin
      rc(ofs[i], 8'h00);
      wr(ofs[i], 8'hff);
      rc(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    avs_byteenable <= 4'he;
    wr(`IFE_OFS_EDGE, 8'h0f);
    avs_byteenable <= 4'hf;
    rc(`IFE_OFS_EDGE, 8'h00);
    // Every edge code on both pins, with all enables off.
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`IFE_OFS_EDGE, 8'(c << (2 * p)));
        ext_pin[p] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        q = 8'((c % 2) << (4 + p));
        rc(`IFE_OFS_PRIMARY, q);
        wr(`IFE_OFS_PRIMARY, 8'h00);
        ext_pin[p] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        q = 8'((c / 2) << (4 + p));
        rc(`IFE_OFS_PRIMARY, q);
        wr(`IFE_OFS_PRIMARY, 8'h00);
      end
    end
    // Each internal event sets only its own flag.
    for (int k = 0; k < 7; k++) begin
      evt <= 7'(1 << k);
      @(posedge clk_sys);
      evt <= 7'h00;
      rc(sofs[k], 8'(1 << sbit[k]));
      wr(sofs[k], 8'h00);
    end
    // All nine sources pending at once, served in priority order.
    wr(`IFE_OFS_EDGE, 8'h05);
    wr(`IFE_OFS_SECONDARY, 8'h0f);
    wr(`IFE_OFS_TERTIARY, 8'h03);
    wr(`IFE_OFS_PRIMARY, 8'h0e);
    ext_pin <= 2'h3;
    evt <= 7'h7f;
    @(posedge clk_sys);
    evt <= 7'h00;
    repeat (6) @(posedge clk_sys);
    check({7'h0, irq_req}, 8'h00);
    ack_en <= 1'b1;
    for (int v = 0; v < 9; v++) begin
      delay <= 4'(3 * (v % 2));
      t = taken_cnt;
      bus(1'b0, `IFE_OFS_PRIMARY, 8'h00, q);
      wr(`IFE_OFS_PRIMARY, q | 8'h01);
      wait_taken();
      check({4'h0, taken_vec}, 8'(v));
      bus(1'b0, `IFE_OFS_PRIMARY, 8'h00, q);
      check(q & 8'h01, 8'h00);
    end
    rc(`IFE_OFS_PRIMARY, 8'h0e);
    rc(`IFE_OFS_SECONDARY, 8'h0f);
    rc(`IFE_OFS_TERTIARY, 8'h03);
    // A disabled source flags but never requests.
    wr(`IFE_OFS_TERTIARY, 8'h01);
    wr(`IFE_OFS_PRIMARY, 8'h0f);
    evt <= 7'h40;
    @(posedge clk_sys);
    evt <= 7'h00;
    repeat (4) @(posedge clk_sys);
    check({7'h0, irq_req}, 8'h00);
    rc(`IFE_OFS_TERTIARY, 8'h21);
    // A full stack holds back an enabled request until room returns.
    t = taken_cnt;
    stack_full <= 1'b1;
    evt <= 7'h01;
    @(posedge clk_sys);
    evt <= 7'h00;
    repeat (5) @(posedge clk_sys);
    check({7'h0, irq_req}, 8'h00);
    check(taken_cnt, t);
    stack_full <= 1'b0;
    wait_taken();
    check({4'h0, taken_vec}, 8'h02);
    conclude();
  end
endmodule

bind ife_unit ife_unit_assertions ife_unit_assertions_inst (
  .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ext_pin0(ext_pin0),
  .ext_pin1(ext_pin1), .converter_ovf(converter_ovf),
  .timer_match_p(timer_match_p), .timer_match_a(timer_match_a),
  .low_voltage_evt(low_voltage_evt), .timebase0_ovf(timebase0_ovf),
  .timebase1_ovf(timebase1_ovf), .eeprom_done(eeprom_done),
  .stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector(irq_vector));
